// ==== core/lsi_core.v ====
`timescale 1ns/1ps
`include "lsi_map.vh"

module lsi_core
#(
  parameter AW = 12
)
(
  input  wire          clock,    // interface clock, 20 MHz
  input  wire          reset,    // synchronous, active high
  input  wire          psel,     // apb select
  input  wire          penable,  // apb enable
  input  wire          pwrite,   // apb direction
  input  wire [AW-1:0] paddr,    // apb byte address
  input  wire [31:0]   pwdata,   // apb write data
  output wire [31:0]   prdata,   // apb read data
  output wire          pready,   // apb ready
  output wire          pslverr,  // apb error on unmapped address
  input  wire          lin_rx,   // bus receive pin
  output wire          lin_tx,   // bus transmit pin, high is recessive
  output wire          lin_irq   // processor interrupt, active high
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SYNC = 3'h1;
  localparam [2:0] ST_ID   = 3'h2;
  localparam [2:0] ST_WSW  = 3'h3;
  localparam [2:0] ST_RXD  = 3'h4;
  localparam [2:0] ST_TXD  = 3'h5;

  reg  [31:0] prdata_ff;
  reg  [3:0]  ctrl_ff;
  reg  [7:0]  bth_ff;
  reg  [15:0] bt_ff;
  reg  [7:0]  dlc_ff;
  reg  [7:0]  idrx_ff;
  reg         rd_done_ff;
  reg  [15:0] pend_ff;
  reg  [2:0]  state_ff;
  reg  [6:0]  idx_ff;
  reg  [7:0]  chk_ff;
  reg  [18:0] sync_cnt_ff;
  reg  [2:0]  falls_ff;
  reg         tx_kick_ff;
  reg  [7:0]  tx_kbyte_ff;
  reg  [7:0]  buf_mem [0:63];
  reg         rxf_d_ff;
  reg  [20:0] low_cnt_ff;
  reg         brk_seen_ff;
  reg         tx_busy_ff;
  reg  [9:0]  tx_sh_ff;
  reg  [15:0] tx_dn_ff;
  reg  [3:0]  tx_n_ff;
  reg         tx_done_ff;
  reg         tx_berr_ff;
  reg         rx_busy_ff;
  reg  [15:0] rx_dn_ff;
  reg  [3:0]  rx_n_ff;
  reg  [8:0]  rx_sh_ff;
  reg         rx_done_ff;
  reg  [31:0] rd_mux;
  reg  [15:0] set_vec;
  reg  [15:0] clr_vec;

  wire        rxf;
  wire [3:0]  cur_idx;
  wire [7:0]  vec   = {2'b00, cur_idx, 2'b00};
  wire        byte_transfer_mode   = ctrl_ff[`LSI_C_BTM];
  wire        bit_error_detect_disable  = ctrl_ff[`LSI_C_BIT_ERROR_DETECT_DISABLE];
  wire [15:0] half  = {1'b0, bt_ff[15:1]};
  wire [15:0] bt_m1 = bt_ff - 16'h0001;
  wire        fall  = rxf_d_ff & ~rxf;
  wire        rise  = ~rxf_d_ff & rxf;

  wire        apb_wr  = psel & penable & pwrite;
  wire        apb_rd  = psel & penable & ~pwrite;
  wire        buf_hit = paddr[11:8] == `LSI_A_BUF;
  wire        reg_hit = (paddr == `LSI_A_CTRL) | (paddr == `LSI_A_VEC) |
                        (paddr == `LSI_A_BTH) | (paddr == `LSI_A_BTL) |
                        (paddr == `LSI_A_IDD) | (paddr == `LSI_A_DLC);

  wire [6:0]  len     = (dlc_ff[5:0] == 6'h00) ? 7'h40 : {1'b0, dlc_ff[5:0]};
  wire [7:0]  rx_byte = rx_sh_ff[7:0];
  wire        rx_frm  = ~rx_sh_ff[8];
  wire        rx_ok   = rx_done_ff & ~rx_frm;
  wire        in_id   = ~byte_transfer_mode & (state_ff == ST_ID);
  wire        in_rxd  = ~byte_transfer_mode & (state_ff == ST_RXD);
  wire        in_txd  = ~byte_transfer_mode & (state_ff == ST_TXD);
  wire        rx_en   = ~tx_busy_ff & (byte_transfer_mode | in_id | in_rxd);
  wire        par_ok  = rx_byte[7:6] ==
                        {~(rx_byte[1] ^ rx_byte[3] ^ rx_byte[4] ^ rx_byte[5]),
                         rx_byte[0] ^ rx_byte[1] ^ rx_byte[2] ^ rx_byte[4]};
  wire        last    = idx_ff == len;
  wire        rxd_dat = in_rxd & rx_ok & ~last;
  wire        rxd_chk = in_rxd & rx_ok & last;
  wire        chk_ok  = rx_byte == ~chk_ff;
  wire        ovr     = pend_ff[`LSI_S_RXF] & ~rd_done_ff;
  wire        wake_ev = ctrl_ff[`LSI_C_WAIT] & fall;
  wire [20:0] brk_min = bt_ff * `LSI_BRK_MULT;
  wire        dlc_wr  = apb_wr & (paddr == `LSI_A_DLC);
  wire        idd_wr  = apb_wr & (paddr == `LSI_A_IDD);
  wire [7:0]  chk_ini = pwdata[`LSI_D_CHK] ? idrx_ff : 8'h00;

  function [7:0] csum;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s    = {1'b0, a} + {1'b0, b};
      csum = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  lsi_rx_filter u_filt
  (
    .clock   (clock),
    .reset   (reset),
    .raw_in  (lin_rx),
    .filt_ff (rxf)
  );

  lsi_vec_prio u_prio
  (
    .pend_in (pend_ff),
    .idx_out (cur_idx)
  );

  // apb: read data captured in setup, answered with no wait state
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~(buf_hit | reg_hit);
  assign prdata  = prdata_ff;
  assign lin_tx  = tx_sh_ff[0];
  assign lin_irq = ctrl_ff[`LSI_C_IE] & (cur_idx != 4'h0);

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `LSI_A_CTRL: rd_mux = {28'h000_0000, ctrl_ff};
      `LSI_A_VEC:  rd_mux = {24'h00_0000, vec};
      `LSI_A_BTH:  rd_mux = {24'h00_0000, bt_ff[15:8]};
      `LSI_A_BTL:  rd_mux = {24'h00_0000, bt_ff[7:0]};
      `LSI_A_IDD:  rd_mux = {24'h00_0000, idrx_ff};
      `LSI_A_DLC:  rd_mux = {24'h00_0000, dlc_ff};
      default:
        if (buf_hit)
          rd_mux = {24'h00_0000, buf_mem[paddr[7:2]]};
    endcase
  end

  always @(posedge clock)
  begin
    if (reset)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_ff <= rd_mux;
  end

  // event sources
  always @*
  begin
    set_vec = 16'h0000;
    set_vec[`LSI_S_TXE]    = byte_transfer_mode & tx_done_ff;
    set_vec[`LSI_S_RXF]    = (byte_transfer_mode & rx_ok & ~ovr) | (rxd_chk & chk_ok);
    set_vec[`LSI_S_OVR]    = byte_transfer_mode & rx_ok & ovr;
    set_vec[`LSI_S_FRM]    = rx_done_ff & rx_frm & (byte_transfer_mode | in_id | in_rxd);
    set_vec[`LSI_S_IDP]    = in_id & rx_ok & ~par_ok;
    set_vec[`LSI_S_IDR]    = in_id & rx_ok & par_ok;
    set_vec[`LSI_S_CHK]    = rxd_chk & ~chk_ok;
    set_vec[`LSI_S_BERR]   = tx_berr_ff;
    set_vec[`LSI_S_TXDONE] = in_txd & tx_done_ff & (idx_ff > len);
    set_vec[`LSI_S_WAKE]   = wake_ev;
  end

  always @*
  begin
    clr_vec = 16'h0000;
    if (apb_wr && paddr == `LSI_A_VEC)
      clr_vec[cur_idx] = 1'b1;
    // receive full needs data read first
    if (cur_idx == `LSI_S_RXF && !rd_done_ff)
      clr_vec[`LSI_S_RXF] = 1'b0;
  end

  always @(posedge clock)
  begin
    if (reset)
    begin
      pend_ff    <= 16'h0000;
      rd_done_ff <= 1'b0;
      idrx_ff    <= 8'h00;
    end
    else
    begin
      pend_ff <= ((pend_ff & ~clr_vec) | set_vec) & 16'hFFFE;
      if (set_vec[`LSI_S_RXF])
        rd_done_ff <= 1'b0;
      else if (apb_rd && paddr == `LSI_A_IDD)
        rd_done_ff <= 1'b1;
      if ((byte_transfer_mode && rx_ok && !ovr) || (in_id && rx_ok && par_ok))
        idrx_ff <= rx_byte;
    end
  end

  always @(posedge clock)
  begin
    if (rxd_dat)
      buf_mem[idx_ff[5:0]] <= rx_byte;
    else if (apb_wr && buf_hit)
      buf_mem[paddr[7:2]] <= pwdata[7:0];
  end

  // break detection from a long low level
  always @(posedge clock)
  begin
    if (reset)
    begin
      rxf_d_ff    <= 1'b1;
      low_cnt_ff  <= 21'h00_0000;
      brk_seen_ff <= 1'b0;
    end
    else
    begin
      rxf_d_ff <= rxf;
      if (rxf)
        low_cnt_ff <= 21'h00_0000;
      else if (low_cnt_ff != 21'h1F_FFFF)
        low_cnt_ff <= low_cnt_ff + 21'h00_0001;
      if (rise)
        brk_seen_ff <= 1'b0;
      else if (!rxf && low_cnt_ff >= brk_min)
        brk_seen_ff <= 1'b1;
    end
  end

  // control registers and frame sequencer
  always @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_ff     <= 4'h0;
      bth_ff      <= 8'h00;
      bt_ff       <= `LSI_BT_RESET;
      dlc_ff      <= 8'h00;
      state_ff    <= ST_IDLE;
      idx_ff      <= 7'h00;
      chk_ff      <= 8'h00;
      sync_cnt_ff <= 19'h0_0000;
      falls_ff    <= 3'h0;
      tx_kick_ff  <= 1'b0;
      tx_kbyte_ff <= 8'h00;
    end
    else
    begin
      tx_kick_ff <= 1'b0;
      if (apb_wr && paddr == `LSI_A_CTRL)
        ctrl_ff <= pwdata[3:0];
      else if (wake_ev)
        ctrl_ff[`LSI_C_WAIT] <= 1'b0;
      if (apb_wr && paddr == `LSI_A_BTH)
        bth_ff <= pwdata[7:0];
      if (apb_wr && paddr == `LSI_A_BTL)
        bt_ff <= {bth_ff, pwdata[7:0]};
      if (dlc_wr)
        dlc_ff <= pwdata[7:0];
      if (byte_transfer_mode)
      begin
        state_ff <= ST_IDLE;
        if (idd_wr && !tx_busy_ff)
        begin
          tx_kick_ff  <= 1'b1;
          tx_kbyte_ff <= pwdata[7:0];
        end
      end
      else if (brk_seen_ff && rise)
      begin
        state_ff    <= ST_SYNC;
        falls_ff    <= 3'h0;
        sync_cnt_ff <= 19'h0_0000;
      end
      else
      begin
        case (state_ff)
          ST_IDLE:
            idx_ff <= 7'h00;
          ST_SYNC:
          begin
            sync_cnt_ff <= sync_cnt_ff + 19'h0_0001;
            if (fall)
            begin
              falls_ff <= falls_ff + 3'h1;
              if (falls_ff == 3'h0)
                sync_cnt_ff <= 19'h0_0001;
              // eight bits between first and fifth edge
              if (falls_ff == `LSI_SYNC_FALLS)
              begin
                bt_ff    <= sync_cnt_ff[18:3];
                state_ff <= ST_ID;
              end
            end
          end
          ST_ID:
            if (rx_done_ff)
              state_ff <= (rx_ok && par_ok) ? ST_WSW : ST_IDLE;
          ST_WSW:
            if (dlc_wr)
            begin
              idx_ff <= 7'h00;
              chk_ff <= chk_ini;
              if (pwdata[`LSI_D_GO])
              begin
                state_ff    <= ST_TXD;
                tx_kick_ff  <= 1'b1;
                tx_kbyte_ff <= buf_mem[0];
                chk_ff      <= csum(chk_ini, buf_mem[0]);
                idx_ff      <= 7'h01;
              end
              else
                state_ff <= ST_RXD;
            end
          ST_RXD:
            if (rxd_dat)
            begin
              chk_ff <= csum(chk_ff, rx_byte);
              idx_ff <= idx_ff + 7'h01;
            end
            else if (rx_done_ff)
              state_ff <= ST_IDLE;
          ST_TXD:
            if (tx_berr_ff)
            begin
              state_ff            <= ST_IDLE;
              dlc_ff[`LSI_D_GO]   <= 1'b0;
            end
            else if (tx_done_ff)
            begin
              idx_ff <= idx_ff + 7'h01;
              if (idx_ff < len)
              begin
                tx_kick_ff  <= 1'b1;
                tx_kbyte_ff <= buf_mem[idx_ff[5:0]];
                chk_ff      <= csum(chk_ff, buf_mem[idx_ff[5:0]]);
              end
              else if (last)
              begin
                tx_kick_ff  <= 1'b1;
                tx_kbyte_ff <= ~chk_ff;
              end
              else
              begin
                state_ff          <= ST_IDLE;
                dlc_ff[`LSI_D_GO] <= 1'b0;
              end
            end
          default:
            state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // transmitter: start, 8 data lsb first, stop
  always @(posedge clock)
  begin
    if (reset)
    begin
      tx_busy_ff <= 1'b0;
      tx_sh_ff   <= 10'h3FF;
      tx_dn_ff   <= 16'h0000;
      tx_n_ff    <= 4'h0;
      tx_done_ff <= 1'b0;
      tx_berr_ff <= 1'b0;
    end
    else
    begin
      tx_done_ff <= 1'b0;
      tx_berr_ff <= 1'b0;
      if (tx_kick_ff)
      begin
        tx_busy_ff <= 1'b1;
        tx_sh_ff   <= {1'b1, tx_kbyte_ff, 1'b0};
        tx_dn_ff   <= bt_m1;
        tx_n_ff    <= 4'h0;
      end
      else if (tx_busy_ff)
      begin
        if (!bit_error_detect_disable && tx_dn_ff == half && rxf != tx_sh_ff[0])
        begin
          tx_busy_ff <= 1'b0;
          tx_sh_ff   <= 10'h3FF;
          tx_berr_ff <= 1'b1;
        end
        else if (tx_dn_ff == 16'h0000)
        begin
          tx_dn_ff <= bt_m1;
          tx_n_ff  <= tx_n_ff + 4'h1;
          tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
          if (tx_n_ff == `LSI_STOP_BIT)
          begin
            tx_busy_ff <= 1'b0;
            tx_sh_ff   <= 10'h3FF;
            tx_done_ff <= 1'b1;
          end
        end
        else
          tx_dn_ff <= tx_dn_ff - 16'h0001;
      end
    end
  end

  // receiver
  always @(posedge clock)
  begin
    if (reset)
    begin
      rx_busy_ff <= 1'b0;
      rx_dn_ff   <= 16'h0000;
      rx_n_ff    <= 4'h0;
      rx_sh_ff   <= 9'h1FF;
      rx_done_ff <= 1'b0;
    end
    else
    begin
      rx_done_ff <= 1'b0;
      if (!rx_busy_ff)
      begin
        // first sample half a bit after the edge
        if (fall && rx_en)
        begin
          rx_busy_ff <= 1'b1;
          rx_dn_ff   <= half;
          rx_n_ff    <= 4'h0;
        end
      end
      else if (rx_dn_ff == 16'h0000)
      begin
        rx_dn_ff <= bt_m1;
        rx_n_ff  <= rx_n_ff + 4'h1;
        if (rx_n_ff == 4'h0)
        begin
          if (rxf)
            rx_busy_ff <= 1'b0;
        end
        else
        begin
          rx_sh_ff <= {rxf, rx_sh_ff[8:1]};
          if (rx_n_ff == `LSI_STOP_BIT)
          begin
            rx_busy_ff <= 1'b0;
            rx_done_ff <= 1'b1;
          end
        end
      end
      else if (fall)
        rx_dn_ff <= half;
      else
        rx_dn_ff <= rx_dn_ff - 16'h0001;
    end
  end

endmodule

// ==== core/lsi_map.vh ====
`ifndef LSI_MAP_VH
`define LSI_MAP_VH

// register byte offsets
`define LSI_A_CTRL     12'h000
`define LSI_A_VEC      12'h004
`define LSI_A_BTH      12'h008
`define LSI_A_BTL      12'h00C
`define LSI_A_IDD      12'h010
`define LSI_A_DLC      12'h014
// frame buffer page: 0x100 + 4*index
`define LSI_A_BUF      4'h1

// control register fields
`define LSI_C_BTM      0
`define LSI_C_BIT_ERROR_DETECT_DISABLE     1
`define LSI_C_IE       2
`define LSI_C_WAIT     3

// data length register fields
`define LSI_D_CHK      6
`define LSI_D_GO       7

// source numbers, equal to priority; vector = source * 4
`define LSI_S_TXDONE   3
`define LSI_S_TXE      4
`define LSI_S_RXF      5
`define LSI_S_IDR      6
`define LSI_S_CHK      7
`define LSI_S_OVR      8
`define LSI_S_BERR     9
`define LSI_S_FRM      10
`define LSI_S_IDP      11
`define LSI_S_WAKE     15

// reset values and counts
`define LSI_BT_RESET   16'h0823
`define LSI_BRK_MULT   5'h0B
`define LSI_SYNC_FALLS 3'h4
`define LSI_STOP_BIT   4'h9
`define LSI_FILT_MAX   4'hF

`endif

// ==== core/lsi_rx_filter.v ====
`timescale 1ns/1ps
`include "lsi_map.vh"

module lsi_rx_filter
#(
  parameter CW = 4
)
(
  input  wire          clock,    // interface clock
  input  wire          reset,    // synchronous, active high
  input  wire          raw_in,   // bus receive pin
  output reg           filt_ff   // filtered receive level
);

  localparam [CW-1:0] CMAX = `LSI_FILT_MAX;

  reg  [CW-1:0] cnt_ff;
  reg  [CW-1:0] nxt_cnt;

  always @*
  begin
    nxt_cnt = cnt_ff;
    if (raw_in && cnt_ff != CMAX)
      nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    else if (!raw_in && cnt_ff != {CW{1'b0}})
      nxt_cnt = cnt_ff - {{(CW-1){1'b0}}, 1'b1};
  end

  always @(posedge clock)
  begin
    if (reset)
    begin
      cnt_ff  <= CMAX;
      filt_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      if (nxt_cnt == CMAX)
        filt_ff <= 1'b1;
      else if (nxt_cnt == {CW{1'b0}})
        filt_ff <= 1'b0;
    end
  end

endmodule

// ==== core/lsi_vec_prio.v ====
`timescale 1ns/1ps

module lsi_vec_prio
(
  input  wire [15:0] pend_in,   // pending sources, bit n = priority n
  output reg  [3:0]  idx_out    // highest pending source, 0 when none
);

  integer i;

  always @*
  begin
    idx_out = 4'h0;
    for (i = 1; i < 16; i = i + 1)
      if (pend_in[i])
        idx_out = i[3:0];
  end

endmodule

// ==== verification/lsi_core_checker.sv ====
`timescale 1ns/1ps
`include "lsi_map.vh"
module lsi_core_checker
#(
  parameter AW = 12
)
(
  input wire logic          clock,    // interface clock
  input wire logic          reset,    // synchronous reset
  input wire logic          psel,     // apb select
  input wire logic          penable,  // apb enable
  input wire logic          pwrite,   // apb direction
  input wire logic [AW-1:0] paddr,    // apb address
  input wire logic [31:0]   pwdata,   // apb write data
  input wire logic [31:0]   prdata,   // apb read data
  input wire logic          pready,   // apb ready
  input wire logic          pslverr,  // apb error
  input wire logic          lin_rx,   // bus receive
  input wire logic          lin_tx,   // bus transmit
  input wire logic          lin_irq   // interrupt
);
  logic ie_ff;
  logic nxt_ie;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_vec_setup;
    psel && !penable && !pwrite && paddr == `LSI_A_VEC;
  endsequence
  sequence s_irq_read;
    s_vec_setup ##0 lin_irq;
  endsequence

  // shadow of the interrupt enable bit, taken from apb writes
  always_comb
    nxt_ie = (psel && penable && pwrite && paddr == `LSI_A_CTRL) ? pwdata[`LSI_C_IE] : ie_ff;
  always_ff @(posedge clock)
    if (reset)
      ie_ff <= 1'b0;
    else
      ie_ff <= nxt_ie;

  a_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not tied to the access phase");
  a_err_unmapped: assert property ((psel && penable && paddr == 12'h018) |-> pslverr)
    else $error("unmapped access without pslverr");
  a_err_mapped: assert property
    ((psel && penable && paddr <= `LSI_A_DLC && paddr[1:0] == 2'b00) |-> !pslverr)
    else $error("pslverr on a mapped register");
  a_vec_format: assert property
    (s_vec_setup |=> prdata[31:6] == 0 && prdata[1:0] == 0 && prdata[5:0] != 6'h38)
    else $error("vector read outside the encoding");
  a_irq_vec_zero: assert property (s_irq_read |=> prdata != 0)
    else $error("interrupt raised with an empty vector");
  a_irq_masked: assert property (!ie_ff |-> !lin_irq)
    else $error("interrupt raised while disabled");
  a_prdata_hold: assert property
    ((!$past(reset) && !($past(psel) && !$past(penable))) |-> $stable(prdata))
    else $error("read data changed without a read setup");
  a_tx_idle_reset: assert property ($fell(reset) |-> lin_tx && !lin_irq)
    else $error("bus or interrupt not idle after reset");
endmodule

bind lsi_core lsi_core_checker #(.AW(AW)) i_chk (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .lin_rx(lin_rx), .lin_tx(lin_tx), .lin_irq(lin_irq));

// ==== verification/lsi_lin_master.sv ====
`timescale 1ns/1ps
module lsi_lin_master
(
  input  wire logic clock,   // interface clock
  input  wire logic lin_tx,  // slave transmit level
  output wire logic lin_rx   // resolved bus level
);
  logic drv;
  logic jam;
  logic hold_ff;

  initial
  begin
    drv = 1'b1;
    jam = 1'b0;
    hold_ff = 1'b0;
  end

  // collision: once armed, bus held dominant from the slave's start bit
  always @(posedge clock)
    hold_ff <= jam & (hold_ff | ~lin_tx);

  // wired-and bus, recessive high by pull-up
  assign lin_rx = lin_tx & drv & ~hold_ff;

  task automatic send_byte(input logic [7:0] b, input logic stop, input int bt);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    // start low, lsb first, stop last
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      drv <= f[i];
      repeat (bt - 1) @(posedge clock);
    end
    @(posedge clock);
    drv <= 1'b1;
    repeat (2 * bt) @(posedge clock);
  endtask

  task automatic send_header(input logic [7:0] id, input int brk, input int bt);
    @(posedge clock);
    drv <= 1'b0;
    repeat (brk) @(posedge clock);
    drv <= 1'b1;
    repeat (bt) @(posedge clock);
    send_byte(8'h55, 1'b1, bt);
    send_byte(id, 1'b1, bt);
  endtask
endmodule

// ==== verification/lin_slave_interface_tb_top.sv ====
`timescale 1ns/1ps
`include "lsi_map.vh"
module lin_slave_interface_tb_top;
  localparam int BT = 64;
  logic        clock;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         lin_rx;
  wire         lin_tx;
  wire         lin_irq;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors;
  int          compares;

  lsi_core #(.AW(12)) i_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lin_rx(lin_rx), .lin_tx(lin_tx), .lin_irq(lin_irq));
  lsi_lin_master i_lin (.clock(clock), .lin_tx(lin_tx), .lin_rx(lin_rx));

  always #25 clock = ~clock;

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      num_errors++;
      give_verdict();
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_vec(input logic [31:0] exp);
    int n;
    n = 0;
    do
    begin
      rd(`LSI_A_VEC);
      n++;
    end
    while (rdata === 32'h0000_0000 && n < 1000);
    chk("vector", exp, rdata);
    if (rdata === 32'h0000_0000)
      give_verdict();
  endtask

  task automatic drain;
    repeat (8)
    begin
      rd(`LSI_A_VEC);
      if (rdata !== 32'h0000_0000)
      begin
        rd(`LSI_A_IDD);
        wr(`LSI_A_VEC, 32'h0000_0000);
      end
    end
    rd(`LSI_A_VEC);
    chk("vector empty", 32'h0000_0000, rdata);
  endtask

  task automatic tx_jammed(input logic [31:0] ctrl, input logic [31:0] exp);
    wr(`LSI_A_CTRL, ctrl);
    i_lin.jam <= 1'b1;
    wr(`LSI_A_IDD, 32'h0000_00FF);
    wait_vec(exp);
    i_lin.jam <= 1'b0;
    drain();
  endtask

  // command frame: identifier, one data byte and a checksum byte from the master
  task automatic cmd_frame(input logic [7:0] sum_byte, input logic [31:0] exp);
    i_lin.send_header(8'h3C, 13 * BT, BT);
    wait_vec(8'h18);
    wr(`LSI_A_VEC, 32'h0000_0000);
    wr(`LSI_A_DLC, 32'h0000_0041);
    i_lin.send_byte(8'h5A, 1'b1, BT);
    i_lin.send_byte(sum_byte, 1'b1, BT);
    wait_vec(exp);
  endtask

  initial
  begin
    clock = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    num_errors = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(`LSI_A_BTL);
    chk("bit time low", 8'h23, rdata[7:0]);
    rd(`LSI_A_VEC);
    chk("vector", 8'h00, rdata);
    rd(12'h018);
    chk("unmapped error", 1'b1, rerr);
    chk("unmapped data", 8'h00, rdata);
    $display("test reset done");
    i_lin.send_header(8'h3C, 27100, BT);
    wait_vec(8'h18);
    rd(`LSI_A_BTL);
    chk("measured bit time", 8'h40, rdata[7:0]);
    wr(`LSI_A_VEC, 32'h0000_0000);
    wr(12'h100, 32'h0000_0011);
    wr(`LSI_A_DLC, 32'h0000_0081);
    wait_vec(8'h0C);
    wr(`LSI_A_VEC, 32'h0000_0000);
    i_lin.send_header(8'hBC, 13 * BT, BT);
    wait_vec(8'h2C);
    drain();
    cmd_frame(8'h69, 8'h14);
    rd(12'h100);
    chk("frame byte", 8'h5A, rdata);
    drain();
    cmd_frame(8'h6A, 8'h1C);
    drain();
    $display("test lin mode done");
    wr(`LSI_A_CTRL, 32'h0000_0005);
    wr(`LSI_A_BTH, 32'h0000_0000);
    wr(`LSI_A_BTL, 32'h0000_003E);
    rd(`LSI_A_BTL);
    chk("bit time low", 8'h3E, rdata[7:0]);
    wr(`LSI_A_BTH, 32'h0000_0001);
    rd(`LSI_A_BTH);
    chk("bit time staged", 2'b00, {rdata[8], rdata[0]});
    wr(`LSI_A_BTH, 32'h0000_0000);
    wr(`LSI_A_BTL, 32'h0000_0040);
    $display("test bit time done");
    wr(`LSI_A_IDD, 32'h0000_00A5);
    wait_vec(8'h10);
    wr(`LSI_A_VEC, 32'h0000_0000);
    tx_jammed(32'h0000_0005, 8'h24);
    tx_jammed(32'h0000_0007, 8'h10);
    wr(`LSI_A_CTRL, 32'h0000_0005);
    $display("test transmit done");
    i_lin.send_byte(8'h3C, 1'b1, BT);
    wait_vec(8'h14);
    chk("irq", 1'b1, lin_irq);
    wr(`LSI_A_VEC, 32'h0000_0000);
    rd(`LSI_A_VEC);
    chk("vector", 8'h14, rdata);
    i_lin.send_byte(8'h5A, 1'b1, BT);
    rd(`LSI_A_VEC);
    chk("vector", 8'h20, rdata);
    wr(`LSI_A_VEC, 32'h0000_0000);
    rd(`LSI_A_VEC);
    chk("vector", 8'h14, rdata);
    rd(`LSI_A_IDD);
    chk("received byte", 8'h3C, rdata[7:0]);
    wr(`LSI_A_VEC, 32'h0000_0000);
    rd(`LSI_A_VEC);
    chk("vector", 8'h00, rdata);
    chk("irq", 1'b0, lin_irq);
    $display("test receive done");
    i_lin.send_byte(8'h00, 1'b0, BT);
    wait_vec(8'h28);
    drain();
    wr(`LSI_A_CTRL, 32'h0000_0001);
    i_lin.send_byte(8'h33, 1'b1, BT);
    wait_vec(8'h14);
    chk("irq masked", 1'b0, lin_irq);
    drain();
    wr(`LSI_A_CTRL, 32'h0000_0009);
    i_lin.send_byte(8'h55, 1'b1, BT);
    wait_vec(8'h3C);
    drain();
    $display("test events done");
    give_verdict();
  end
endmodule
